/* arcs_pkg.sv */
// constants and types shared by the retry-limit and compare-swap register block
package arcs_pkg;

  // register byte offsets on the host register port
  localparam logic [7:0]  OFS_RETRY      = 8'h08;  // transmit retry limits
  localparam logic [7:0]  OFS_SWAP_NEW   = 8'h0c;  // value stored on a successful compare
  localparam logic [7:0]  OFS_SWAP_CMP   = 8'h10;  // value compared with the resource
  localparam logic [7:0]  OFS_SWAP_CTRL  = 8'h14;  // completion flag and resource selector

  // retry register field layout
  localparam int          RETRY_CNT_W    = 4;      // width of each retry count
  localparam int          PHYS_RETRY_LSB = 8;      // physical_response_retry_count 11:8
  localparam int          ARSP_RETRY_LSB = 4;      // async_response_retry_count 7:4
  localparam int          AREQ_RETRY_LSB = 0;      // async_request_retry_count 3:0
  localparam int          RETRY_RW_W     = 12;     // writable bits 11:0
  localparam int          RETRY_ZERO_W   = 20;     // bits 31:12 read as zero

  // swap control field layout
  localparam int          SWAP_SEL_W     = 2;      // swap_resource_selector 1:0
  localparam int          SWAP_RSVD_W    = 29;     // bits 30:2 read as zero
  localparam int          SWAP_DONE_BIT  = 31;     // swap_complete_flag

  // reset values
  localparam logic [11:0] RETRY_RST      = 12'h000;
  localparam logic [31:0] SWAP_NEW_RST   = 32'h00000000;
  localparam logic [31:0] SWAP_CMP_RST   = 32'h00000000;
  localparam logic        SWAP_DONE_RST  = 1'b1;
  localparam logic [1:0]  SWAP_SEL_RST   = 2'h0;
  localparam logic [3:0]  RETRY_CNT_RST  = 4'h0;

  // resource selector codes
  localparam logic [1:0]  RES_BUS_MANAGER_ID   = 2'h0;
  localparam logic [1:0]  RES_BANDWIDTH_AVAIL  = 2'h1;
  localparam logic [1:0]  RES_CHANNELS_HI      = 2'h2;
  localparam logic [1:0]  RES_CHANNELS_LO      = 2'h3;
  localparam int          RES_COUNT            = 4;

  // start-up contents of the four bus-management resources, index = selector code
  localparam logic [31:0] RES_INIT_BM_ID = 32'h00000000;
  localparam logic [31:0] RES_INIT_BW    = 32'h00000000;
  localparam logic [31:0] RES_INIT_CH_HI = 32'hffffffff;
  localparam logic [31:0] RES_INIT_CH_LO = 32'hffffffff;

  // compare-swap sequencer states
  typedef enum logic [1:0] {
    SWAP_IDLE,
    SWAP_COMPARE,
    SWAP_COMMIT
  } arcs_swap_state_t;

endpackage // arcs_pkg

/* arcs_regs.sv */
// retry-limit and compare-swap register bank of the host controller
`timescale 1ns/100ps
module arcs_regs (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // host register port
  input  wire logic [7:0]  HOST_ADDR,
  input  wire logic        HOST_WR,
  input  wire logic        HOST_RD,
  input  wire logic [31:0] HOST_WDATA,
  output logic      [31:0] HOST_RDATA,
  // physical response unit
  input  wire logic        PHYS_TX_DONE,
  input  wire logic        PHYS_TX_BUSY,
  output logic             PHYS_RETRY,
  output logic             PHYS_GIVE_UP,
  // asynchronous response unit
  input  wire logic        ARSP_TX_DONE,
  input  wire logic        ARSP_TX_BUSY,
  output logic             ARSP_RETRY,
  output logic             ARSP_GIVE_UP,
  // asynchronous request unit
  input  wire logic        AREQ_TX_DONE,
  input  wire logic        AREQ_TX_BUSY,
  output logic             AREQ_RETRY,
  output logic             AREQ_GIVE_UP,
  // compare-swap status
  output logic             SWAP_BUSY
);

  // register state
  logic [11:0]                  retry_q;        // three writable retry counts
  logic [31:0]                  new_q;          // swap_new_value
  logic [31:0]                  new_d;
  logic [31:0]                  cmp_q;          // swap_compare_value
  logic [1:0]                   sel_q;          // swap_resource_selector
  logic                         done_q;         // swap_complete_flag
  logic                         done_d;
  logic [31:0]                  rdata_q;        // registered read answer
  logic                         busy_q;         // swap in flight, for SWAP_BUSY

  // compare-swap engine state
  arcs_pkg::arcs_swap_state_t   state_q;
  arcs_pkg::arcs_swap_state_t   state_d;
  logic [31:0]                  res_q [arcs_pkg::RES_COUNT];  // bus-management resources
  logic [31:0]                  old_q;          // resource value seen at compare
  logic                         match_q;        // compare result

  // address decode
  wire        wr_retry = HOST_WR && (HOST_ADDR == arcs_pkg::OFS_RETRY);
  wire        wr_new   = HOST_WR && (HOST_ADDR == arcs_pkg::OFS_SWAP_NEW);
  wire        wr_cmp   = HOST_WR && (HOST_ADDR == arcs_pkg::OFS_SWAP_CMP);
  wire        wr_ctrl  = HOST_WR && (HOST_ADDR == arcs_pkg::OFS_SWAP_CTRL);

  // retry count fields
  wire [3:0]  phys_lim = retry_q[arcs_pkg::PHYS_RETRY_LSB +: arcs_pkg::RETRY_CNT_W];
  wire [3:0]  arsp_lim = retry_q[arcs_pkg::ARSP_RETRY_LSB +: arcs_pkg::RETRY_CNT_W];
  wire [3:0]  areq_lim = retry_q[arcs_pkg::AREQ_RETRY_LSB +: arcs_pkg::RETRY_CNT_W];

  // read words; unused fields are constant zero
  wire [31:0] retry_word = {{arcs_pkg::RETRY_ZERO_W{1'b0}}, retry_q};
  wire [31:0] ctrl_word  = {done_q, {arcs_pkg::SWAP_RSVD_W{1'b0}}, sel_q};
  wire [31:0] rd_word    = (HOST_ADDR == arcs_pkg::OFS_RETRY)     ? retry_word :
                           (HOST_ADDR == arcs_pkg::OFS_SWAP_NEW)  ? new_q      :
                           (HOST_ADDR == arcs_pkg::OFS_SWAP_CMP)  ? cmp_q      :
                           (HOST_ADDR == arcs_pkg::OFS_SWAP_CTRL) ? ctrl_word  : 32'h00000000;

  // engine decode
  wire [1:0]  cur_sel    = sel_q;
  wire [31:0] cur_res    = res_q[cur_sel];
  wire        finishing  = (state_q == arcs_pkg::SWAP_COMMIT) && !wr_ctrl;
  wire        commit_wr  = finishing && match_q;

  // next state: a control write always (re)starts from the compare step
  always_comb begin
    state_d = state_q;
    case (state_q)
      arcs_pkg::SWAP_IDLE: begin
        if (wr_ctrl) state_d = arcs_pkg::SWAP_COMPARE;
      end
      arcs_pkg::SWAP_COMPARE: begin
        // a new write aborts and restarts on the new selection
        state_d = arcs_pkg::SWAP_COMMIT;
      end
      arcs_pkg::SWAP_COMMIT: begin
        state_d = wr_ctrl ? arcs_pkg::SWAP_COMPARE : arcs_pkg::SWAP_IDLE;
      end
      default: begin
        state_d = arcs_pkg::SWAP_IDLE;
      end
    endcase
    if (wr_ctrl) state_d = arcs_pkg::SWAP_COMPARE;
  end

  // completion flag: write clears; a write in the finishing cycle aborts that swap,
  // so there is never a completion and a clear in the same cycle to arbitrate
  assign done_d = wr_ctrl ? 1'b0 : (finishing ? 1'b1 : done_q);

  // new value: the host write wins; on completion it returns the old resource value
  assign new_d  = wr_new ? HOST_WDATA : (finishing ? old_q : new_q);

  // host-writable registers
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      retry_q <= arcs_pkg::RETRY_RST;
      new_q   <= arcs_pkg::SWAP_NEW_RST;
      cmp_q   <= arcs_pkg::SWAP_CMP_RST;
      sel_q   <= arcs_pkg::SWAP_SEL_RST;
    end else begin
      if (wr_retry) retry_q <= HOST_WDATA[arcs_pkg::RETRY_RW_W-1:0];
      new_q <= new_d;
      if (wr_cmp)   cmp_q   <= HOST_WDATA;
      if (wr_ctrl)  sel_q   <= HOST_WDATA[arcs_pkg::SWAP_SEL_W-1:0];
    end
  end

  // engine sequencing and flag
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state_q <= arcs_pkg::SWAP_IDLE;
      done_q  <= arcs_pkg::SWAP_DONE_RST;
      busy_q  <= 1'b0;
      old_q   <= 32'h00000000;
      match_q <= 1'b0;
    end else begin
      state_q <= state_d;
      done_q  <= done_d;
      busy_q  <= (state_d != arcs_pkg::SWAP_IDLE);
      if (state_q == arcs_pkg::SWAP_COMPARE) begin
        old_q   <= cur_res;
        match_q <= (cur_res == cmp_q);
      end
    end
  end

  // resource storage, written only by a successful compare
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      res_q[arcs_pkg::RES_BUS_MANAGER_ID]  <= arcs_pkg::RES_INIT_BM_ID;
      res_q[arcs_pkg::RES_BANDWIDTH_AVAIL] <= arcs_pkg::RES_INIT_BW;
      res_q[arcs_pkg::RES_CHANNELS_HI]     <= arcs_pkg::RES_INIT_CH_HI;
      res_q[arcs_pkg::RES_CHANNELS_LO]     <= arcs_pkg::RES_INIT_CH_LO;
    end else if (commit_wr) begin
      res_q[cur_sel] <= new_q;
    end
  end

  // registered read answer, zero when no read is asked
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= HOST_RD ? rd_word : 32'h00000000;
    end
  end

  assign HOST_RDATA = rdata_q;
  assign SWAP_BUSY  = busy_q;

  // one retry tracker per transmit unit; each reads its own count field
  arcs_retry_track u_phys_retry (
    .clk          (CLK),
    .rstn         (RSTN),
    .limit        (phys_lim),
    .tx_done      (PHYS_TX_DONE),
    .tx_retry_ack (PHYS_TX_BUSY),
    .retry        (PHYS_RETRY),
    .give_up      (PHYS_GIVE_UP),
    .tries        ()
  );

  arcs_retry_track u_arsp_retry (
    .clk          (CLK),
    .rstn         (RSTN),
    .limit        (arsp_lim),
    .tx_done      (ARSP_TX_DONE),
    .tx_retry_ack (ARSP_TX_BUSY),
    .retry        (ARSP_RETRY),
    .give_up      (ARSP_GIVE_UP),
    .tries        ()
  );

  arcs_retry_track u_areq_retry (
    .clk          (CLK),
    .rstn         (RSTN),
    .limit        (areq_lim),
    .tx_done      (AREQ_TX_DONE),
    .tx_retry_ack (AREQ_TX_BUSY),
    .retry        (AREQ_RETRY),
    .give_up      (AREQ_GIVE_UP),
    .tries        ()
  );

  // reading the retry register shows nothing in the second-bound field
  second_bound_zero_a : assert property (@(posedge CLK) disable iff (!RSTN)
    (HOST_RD && HOST_ADDR == arcs_pkg::OFS_RETRY) |=> (HOST_RDATA[31:29] == 3'h0))
    else $error("second bound field not zero");

  // reading the retry register shows nothing in the cycle-bound field
  cycle_bound_zero_a : assert property (@(posedge CLK) disable iff (!RSTN)
    (HOST_RD && HOST_ADDR == arcs_pkg::OFS_RETRY) |=> (HOST_RDATA[28:16] == 13'h0000))
    else $error("cycle bound field not zero");

  // reserved retry bits read zero, writable bits read back what was written
  retry_readback_a : assert property (@(posedge CLK) disable iff (!RSTN)
    (wr_retry ##1 (HOST_RD && HOST_ADDR == arcs_pkg::OFS_RETRY && !HOST_WR))
      |=> (HOST_RDATA == {20'h00000, $past(HOST_WDATA[11:0], 2)}))
    else $error("retry register read back wrong");

  // a successful compare stores the new value into the selected resource
  swap_store_a : assert property (@(posedge CLK) disable iff (!RSTN)
    commit_wr |=> (res_q[$past(sel_q)] == $past(new_q)))
    else $error("swap did not store the new value");

  // the compare step checks the compare register against the selected resource
  swap_compare_a : assert property (@(posedge CLK) disable iff (!RSTN)
    (state_q == arcs_pkg::SWAP_COMPARE && !wr_ctrl)
      |=> (match_q == ($past(res_q[sel_q]) == $past(cmp_q))) && state_q == arcs_pkg::SWAP_COMMIT)
    else $error("compare result wrong");

  // an uninterrupted swap completes two cycles after its control write
  swap_done_a : assert property (@(posedge CLK) disable iff (!RSTN)
    (wr_ctrl ##1 !wr_ctrl ##1 !wr_ctrl) |=> done_q && !busy_q)
    else $error("swap completion flag not set");

  // a control write clears the flag and holds it low while the swap runs
  swap_clear_a : assert property (@(posedge CLK) disable iff (!RSTN)
    wr_ctrl |=> !done_q ##1 !done_q)
    else $error("completion flag not cleared by write");

  // the selector takes the written code
  swap_select_a : assert property (@(posedge CLK) disable iff (!RSTN)
    wr_ctrl |=> (sel_q == $past(HOST_WDATA[1:0])))
    else $error("resource selector not updated");

  // reserved control bits read zero and the flag reads back
  ctrl_reserved_a : assert property (@(posedge CLK) disable iff (!RSTN)
    (HOST_RD && HOST_ADDR == arcs_pkg::OFS_SWAP_CTRL)
      |=> (HOST_RDATA[30:2] == 29'h00000000 && HOST_RDATA[31] == $past(done_q)))
    else $error("control reserved bits not zero");

endmodule // arcs_regs

/* arcs_regs_test.sv */
// self-checking testbench for the retry-limit and compare-swap register bank
`timescale 1ns/100ps
module arcs_regs_test;
  logic        clk;         // 125 MHz bench clock
  logic        rstn;        // synchronous reset, active low
  logic [7:0]  host_addr;   // register byte address
  logic        host_wr;     // write strobe
  logic        host_rd;     // read strobe
  logic [31:0] host_wdata;  // write data
  logic [31:0] host_rdata;  // registered read data
  logic [2:0]  tx_done;     // attempt finished: 0 phys, 1 async resp, 2 async req
  logic [2:0]  tx_busy;     // busy or data-error ack
  logic [2:0]  rty;         // resend pulses
  logic [2:0]  gup;         // give-up pulses
  logic        swap_busy;   // compare-swap in flight
  int          err_count;   // mismatches seen
  int          tests_run;   // comparisons made

  arcs_regs dut (
    .CLK(clk), .RSTN(rstn), .HOST_ADDR(host_addr), .HOST_WR(host_wr), .HOST_RD(host_rd),
    .HOST_WDATA(host_wdata), .HOST_RDATA(host_rdata),
    .PHYS_TX_DONE(tx_done[0]), .PHYS_TX_BUSY(tx_busy[0]), .PHYS_RETRY(rty[0]), .PHYS_GIVE_UP(gup[0]),
    .ARSP_TX_DONE(tx_done[1]), .ARSP_TX_BUSY(tx_busy[1]), .ARSP_RETRY(rty[1]), .ARSP_GIVE_UP(gup[1]),
    .AREQ_TX_DONE(tx_done[2]), .AREQ_TX_BUSY(tx_busy[2]), .AREQ_RETRY(rty[2]), .AREQ_GIVE_UP(gup[2]),
    .SWAP_BUSY(swap_busy)
  );

  // free-running clock, 8 ns period
  always #4 clk = ~clk;

  // one verdict for the whole run
  task automatic final_report;
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // compare and count; case inequality so unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one assignment per edge keeps strobes single-driven in each time step
  task automatic bus(input logic wr, input logic rd, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    host_wr    <= wr;
    host_rd    <= rd;
    host_addr  <= a;
    host_wdata <= d;
  endtask

  // write returns just after the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, 8'h00, 32'h00000000);
  endtask

  // read data lands one cycle after the read edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, 1'b1, a, 32'h00000000);
    bus(1'b0, 1'b0, 8'h00, 32'h00000000);
    #1 check(host_rdata, exp);
  endtask

  // reset values, unmapped accesses, idle read data
  task automatic t_reset;
    wr(8'h18, 32'hffffffff);
    rd(arcs_pkg::OFS_RETRY, 32'h00000000);
    rd(arcs_pkg::OFS_SWAP_CTRL, 32'h80000000);
    rd(arcs_pkg::OFS_SWAP_NEW, 32'h00000000);
    rd(8'h18, 32'h00000000);
    @(posedge clk);
    #1 check(host_rdata, 32'h00000000);
  endtask

  // only bits 11:0 of the retry register hold writes
  task automatic t_retry_reg;
    wr(arcs_pkg::OFS_RETRY, 32'hffffffff);
    rd(arcs_pkg::OFS_RETRY, 32'h00000fff);
    // write then read on the very next edge, so the read-back check sees the pair
    bus(1'b1, 1'b0, arcs_pkg::OFS_RETRY, 32'hfedc5a5a);
    bus(1'b0, 1'b1, arcs_pkg::OFS_RETRY, 32'h00000000);
    bus(1'b0, 1'b0, 8'h00, 32'h00000000);
    #1 check(host_rdata, 32'h00000a5a);
  endtask

  // report one attempt on unit u; the pulse stands in the cycle after the taking edge, then drops
  task automatic tx(input int u, input logic b, input logic er, input logic eg);
    @(posedge clk);
    tx_done <= 3'h1 << u;
    tx_busy <= {3{b}} & (3'h1 << u);
    @(posedge clk);
    tx_done <= 3'h0;
    tx_busy <= 3'h0;
    #1 check({rty, gup}, {3'(er) << u, 3'(eg) << u});
    @(posedge clk);
    #1 check({rty, gup}, 6'h00);
  endtask

  // limits phys 2, async response 1, async request 0
  task automatic t_trackers;
    int lim[3];
    lim = '{2, 1, 0};
    wr(arcs_pkg::OFS_RETRY, 32'h00000210);
    for (int u = 0; u < 3; u++) begin
      for (int k = 0; k < lim[u]; k++) begin
        tx(u, 1'b1, 1'b1, 1'b0);
      end
      tx(u, 1'b1, 1'b0, 1'b1);
      tx(u, 1'b0, 1'b0, 1'b0);
      tx(u, 1'b1, lim[u] > 0, lim[u] == 0);
      tx(u, 1'b0, 1'b0, 1'b0);
    end
  endtask

  // full swap with busy window, flag and old-value return
  task automatic swap(input logic [1:0] s, input logic [31:0] nw, input logic [31:0] cmp, input logic [31:0] old);
    wr(arcs_pkg::OFS_SWAP_NEW, nw);
    wr(arcs_pkg::OFS_SWAP_CMP, cmp);
    wr(arcs_pkg::OFS_SWAP_CTRL, {30'h0, s});
    // busy from the edge that takes the write, through the compare step, low after commit
    #1 check(32'(swap_busy), 32'h1);
    @(posedge clk);
    #1 check(32'(swap_busy), 32'h1);
    @(posedge clk);
    #1 check(32'(swap_busy), 32'h0);
    rd(arcs_pkg::OFS_SWAP_CTRL, {1'b1, 29'h0, s});
    rd(arcs_pkg::OFS_SWAP_NEW, old);
    rd(arcs_pkg::OFS_SWAP_CMP, cmp);
  endtask

  // every selector: a match stores, a later mismatch leaves the resource alone
  task automatic t_swaps;
    logic [31:0] init[4];
    init = '{32'h00000000, 32'h00000000, 32'hffffffff, 32'hffffffff};
    for (int s = 0; s < 4; s++) begin
      swap(2'(s), 32'ha0 + s, init[s], init[s]);
      swap(2'(s), 32'h11, init[s], 32'ha0 + s);
    end
  endtask

  // a control write one cycle after another aborts the first swap
  task automatic t_abort;
    wr(arcs_pkg::OFS_SWAP_NEW, 32'h77);
    wr(arcs_pkg::OFS_SWAP_CMP, 32'ha1);
    bus(1'b1, 1'b0, arcs_pkg::OFS_SWAP_CTRL, 32'h1);
    bus(1'b1, 1'b0, arcs_pkg::OFS_SWAP_CTRL, 32'h2);
    bus(1'b0, 1'b0, 8'h00, 32'h00000000);
    rd(arcs_pkg::OFS_SWAP_CTRL, 32'h00000002);
    repeat (3) @(posedge clk);
    rd(arcs_pkg::OFS_SWAP_CTRL, 32'h80000002);
    rd(arcs_pkg::OFS_SWAP_NEW, 32'ha2);
    // resource 1 must still hold its earlier value
    swap(2'h1, 32'h55, 32'ha1, 32'ha1);
  endtask

  // main sequence
  initial begin
    clk        = 1'b0;
    rstn       = 1'b0;
    host_addr  = 8'h00;
    host_wr    = 1'b0;
    host_rd    = 1'b0;
    host_wdata = 32'h00000000;
    tx_done    = 3'h0;
    tx_busy    = 3'h0;
    err_count  = 0;
    tests_run  = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_retry_reg();
    t_trackers();
    t_swaps();
    t_abort();
    final_report();
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule // arcs_regs_test

/* arcs_retry_track.sv */
// retry counter for one transmit unit, bounded by a host-programmed limit
`timescale 1ns/100ps
module arcs_retry_track (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // programmed limit
  input  wire logic [3:0] limit,
  // transmit outcome from the unit
  input  wire logic       tx_done,
  input  wire logic       tx_retry_ack,
  // decisions back to the unit
  output logic            retry,
  output logic            give_up,
  output logic [3:0]      tries
);

  logic [3:0] count_q;    // retries already spent on the current packet
  logic [3:0] count_d;
  logic       retry_q;    // one-cycle request to resend
  logic       give_up_q;  // one-cycle notice that the limit is spent
  logic       can_retry;  // another attempt is still allowed
  logic       bad_ack;    // busy or data-error acknowledge seen

  // limit is read live, so lowering it mid-packet takes effect at the next ack
  assign can_retry = count_q < limit;
  assign bad_ack   = tx_done && tx_retry_ack;
  assign count_d   = !tx_done ? count_q :
                     (tx_retry_ack && can_retry) ? count_q + 4'h1 : arcs_pkg::RETRY_CNT_RST;

  // counter and decision flops
  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_q   <= arcs_pkg::RETRY_CNT_RST;
      retry_q   <= 1'b0;
      give_up_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      retry_q   <= bad_ack && can_retry;
      give_up_q <= bad_ack && !can_retry;
    end
  end

  assign retry   = retry_q;
  assign give_up = give_up_q;
  assign tries   = count_q;

  // a bad ack under the limit is answered by a resend and one more spent try
  retry_grant_a : assert property (@(posedge clk) disable iff (!rstn)
    (bad_ack && count_q < limit) |=> (retry_q && !give_up_q && count_q == $past(count_q) + 4'h1))
    else $error("retry not granted below the limit");

  // a bad ack at the limit gives up and rearms the counter
  retry_limit_a : assert property (@(posedge clk) disable iff (!rstn)
    (bad_ack && count_q >= limit) |=> (give_up_q && !retry_q && count_q == 4'h0))
    else $error("retry granted past the limit");

  // a good ack never triggers a resend
  retry_clean_a : assert property (@(posedge clk) disable iff (!rstn)
    (tx_done && !tx_retry_ack) |=> (!retry_q && !give_up_q && count_q == 4'h0))
    else $error("resend after a good acknowledge");

endmodule // arcs_retry_track
